// ---- monreg_pkg.sv ----
// constants, offsets and reset values of the monitor register bank
// assumes one system clock; shared by the bank and its assertions
package monreg_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CFG     = 8'h00;
   localparam logic [7:0] OFS_ISTS    = 8'h01;
   localparam logic [7:0] OFS_IMASK   = 8'h03;
   localparam logic [7:0] OFS_CRATE   = 8'h07;
   localparam logic [7:0] OFS_CDIS    = 8'h08;
   localparam logic [7:0] OFS_ONESHOT = 8'h09;
   localparam logic [7:0] OFS_DEEP    = 8'h0a;
   localparam logic [7:0] OFS_ADV     = 8'h0b;
   localparam logic [7:0] OFS_BUSY    = 8'h0c;
   localparam logic [7:0] OFS_RES_LO  = 8'h20;
   localparam logic [7:0] OFS_RES_HI  = 8'h27;
   localparam logic [7:0] OFS_LIM_LO  = 8'h2a;
   localparam logic [7:0] OFS_LIM_HI  = 8'h39;
   localparam logic [7:0] OFS_MAKER   = 8'h3e;
   localparam logic [7:0] OFS_REV     = 8'h3f;

   // ----------------------------------------
   // reset values and field layout
   // ----------------------------------------
   localparam logic [7:0] RST_CFG     = 8'h08;
   localparam logic [7:0] RST_BUSY    = 8'h02;
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] CFG_WMASK   = 8'h8b;
   localparam int         BIT_START   = 0;
   localparam int         BIT_INT_EN  = 1;
   localparam int         BIT_INT_CLR = 3;
   localparam int         BIT_INIT    = 7;
   localparam int         BIT_DEEP    = 0;
   localparam int         NUM_RES     = 8;
   localparam int         NUM_LIM     = 16;

   // ----------------------------------------
   // serial bus addressing
   // ----------------------------------------
   localparam logic [6:0] ADDR_BASE   = 7'h1d;
   localparam logic [3:0] NUM_LEVELS  = 4'h3;
   localparam logic [1:0] LVL_HIGH    = 2'h2;
   localparam logic [2:0] LAST_BIT    = 3'h7;

   // ----------------------------------------
   // serial engine states
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK  = 6'h04,
      ST_WR   = 6'h08,
      ST_RD   = 6'h10,
      ST_RACK = 6'h20
   } bus_state_t;

endpackage

// ---- monitor_register_bank.sv ----
// register bank of an eight-channel monitor, reached over a two-wire serial bus
// assumes SCL, SDA and address straps are asynchronous pins; sequencer on same clock
//
// How it works
// R1: configuration register at 00h, resets to 08h
// R2: read-only status at 01h, resets zero
// R3: mask at 03h blocks status from interrupt
// R4: conversion-rate register at 07h, resets zero
// R5: channel-disable register at 08h, resets zero
// R6: any write to 09h starts one pass
// R7: deep shutdown register at 0Ah, resets zero
// R8: advanced configuration register at 0Bh, resets zero
// R9: read-only busy status at 0Ch, resets 02h
// R10: eight 16-bit results at 20h to 27h
// R11: 8-bit limit registers from 2Ah to 39h
// R12: fixed maker code readable at 3Eh
// R13: fixed revision code readable at 3Fh
// R14: two three-level strap pins give nine addresses
// R15: reading status returns it then clears it
// R16: trigger offset stores nothing, reads zero
// R17: init bit restores defaults, then clears itself
// R18: unmapped reads zero, bad writes ignored
`timescale 1ns/1ps
module monitor_register_bank #(
   parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
   parameter logic [7:0] REV_CODE   = 8'h3c   // arbitrary value
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output wire logic        SDA_O,
   output wire logic        SDA_OE_O,
   input  wire logic [1:0]  ADDR_SELECT_LOW_PIN_I,
   input  wire logic [1:0]  ADDR_SELECT_HIGH_PIN_I,
   input  wire logic [7:0]  STATUS_SET_I,
   input  wire logic        RESULT_WE_I,
   input  wire logic [2:0]  RESULT_CH_I,
   input  wire logic [15:0] RESULT_DATA_I,
   input  wire logic        CONV_BUSY_I,
   input  wire logic        NOT_READY_I,
   input  wire logic [3:0]  LIMIT_SEL_I,
   output wire logic [7:0]  LIMIT_O,
   output wire logic        INT_O,
   output wire logic        INT_OE_O,
   output wire logic        START_O,
   output wire logic        MONITOR_HALT_O,
   output wire logic        ONE_SHOT_O,
   output wire logic        DEEP_SHUTDOWN_O,
   output wire logic [7:0]  CONV_RATE_O,
   output wire logic [7:0]  CHANNEL_DISABLE_O,
   output wire logic [7:0]  ADV_CONFIG_O,
   output wire logic        BUS_ACTIVE_O
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [2:0]                               scl_sy, sda_sy;
      logic [2:0][3:0]                          adr_sy;
      logic                                     scl_f, sda_f;
      logic [3:0]                               adr_f;
      monreg_pkg::bus_state_t                   st;
      logic [2:0]                               bitc;
      logic [7:0]                               shf;
      logic                                     rw, ptr_phase, hi, mack;
      logic [7:0]                               ptr;
      logic                                     sda_drv, int_drv, one_shot;
      logic [7:0]                               cfg, ists, imask, crate, cdis, deep, adv, busy;
      logic [monreg_pkg::NUM_RES-1:0][15:0]     res;
      logic [monreg_pkg::NUM_LIM-1:0][7:0]      lim;
      logic [7:0]                               lim_out;
   } bank_t;

   localparam bank_t RST_STATE = '{
      scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1, hi: 1'b1,
      st: monreg_pkg::ST_IDLE, cfg: monreg_pkg::RST_CFG,
      busy: monreg_pkg::RST_BUSY, default: '0};

   bank_t      q_ff;
   bank_t      nxt_q;
   logic       scl_new, sda_new, scl_rise, scl_fall, start_c, stop_c;
   logic       in_res, in_lim, do_load, ists_rd, trig_wr;
   logic [1:0] lvl0, lvl1;
   logic [3:0] lim_idx, addr_idx;
   logic [6:0] my_addr;
   logic [7:0] byte_in, rd_val;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_q = q_ff;
      nxt_q.one_shot = 1'b0;
      do_load = 1'b0;
      ists_rd = 1'b0;
      trig_wr = 1'b0;
      // pin sampling, a change counts once stages two and three agree
      nxt_q.scl_sy = {q_ff.scl_sy[1:0], SCL_I};
      nxt_q.sda_sy = {q_ff.sda_sy[1:0], SDA_I};
      nxt_q.adr_sy = {q_ff.adr_sy[1:0], ADDR_SELECT_HIGH_PIN_I, ADDR_SELECT_LOW_PIN_I};
      scl_new = (q_ff.scl_sy[1] == q_ff.scl_sy[2]) ? q_ff.scl_sy[2] : q_ff.scl_f;
      sda_new = (q_ff.sda_sy[1] == q_ff.sda_sy[2]) ? q_ff.sda_sy[2] : q_ff.sda_f;
      if (q_ff.adr_sy[1] == q_ff.adr_sy[2]) begin
         nxt_q.adr_f = q_ff.adr_sy[2];
      end
      nxt_q.scl_f = scl_new;
      nxt_q.sda_f = sda_new;
      scl_rise = scl_new & ~q_ff.scl_f;
      scl_fall = ~scl_new & q_ff.scl_f;
      start_c = q_ff.scl_f & scl_new & q_ff.sda_f & ~sda_new;
      stop_c = q_ff.scl_f & scl_new & ~q_ff.sda_f & sda_new;
      byte_in = {q_ff.shf[6:0], sda_new};
      // three-level straps, code 3 counts as high
      lvl0 = (q_ff.adr_f[1:0] > monreg_pkg::LVL_HIGH) ? monreg_pkg::LVL_HIGH : q_ff.adr_f[1:0];
      lvl1 = (q_ff.adr_f[3:2] > monreg_pkg::LVL_HIGH) ? monreg_pkg::LVL_HIGH : q_ff.adr_f[3:2];
      addr_idx = 4'({2'h0, lvl1} * monreg_pkg::NUM_LEVELS) + {2'h0, lvl0};  // R14
      my_addr = monreg_pkg::ADDR_BASE + {3'h0, addr_idx};  // R14
      // read mux
      in_res = (q_ff.ptr >= monreg_pkg::OFS_RES_LO) && (q_ff.ptr <= monreg_pkg::OFS_RES_HI);
      in_lim = (q_ff.ptr >= monreg_pkg::OFS_LIM_LO) && (q_ff.ptr <= monreg_pkg::OFS_LIM_HI);
      lim_idx = 4'(q_ff.ptr - monreg_pkg::OFS_LIM_LO);
      if (in_res) begin
         rd_val = q_ff.hi ? q_ff.res[q_ff.ptr[2:0]][15:8] : q_ff.res[q_ff.ptr[2:0]][7:0];  // R10
      end else if (in_lim) begin
         rd_val = q_ff.lim[lim_idx];  // R11
      end else begin
         case (q_ff.ptr)
            monreg_pkg::OFS_CFG:   rd_val = q_ff.cfg;  // R1
            monreg_pkg::OFS_ISTS:  rd_val = q_ff.ists;  // R2
            monreg_pkg::OFS_IMASK: rd_val = q_ff.imask;  // R3
            monreg_pkg::OFS_CRATE: rd_val = q_ff.crate;  // R4
            monreg_pkg::OFS_CDIS:  rd_val = q_ff.cdis;  // R5
            monreg_pkg::OFS_DEEP:  rd_val = q_ff.deep;  // R7
            monreg_pkg::OFS_ADV:   rd_val = q_ff.adv;  // R8
            monreg_pkg::OFS_BUSY:  rd_val = q_ff.busy;  // R9
            monreg_pkg::OFS_MAKER: rd_val = MAKER_CODE;  // R12
            monreg_pkg::OFS_REV:   rd_val = REV_CODE;  // R13
            default:               rd_val = monreg_pkg::RST_ZERO;  // R16 R18
         endcase
      end
      // defaults restored one cycle after the init bit is set
      if (q_ff.cfg[monreg_pkg::BIT_INIT]) begin
         nxt_q.cfg = monreg_pkg::RST_CFG;  // R17
         nxt_q.ists = monreg_pkg::RST_ZERO;
         nxt_q.imask = monreg_pkg::RST_ZERO;
         nxt_q.crate = monreg_pkg::RST_ZERO;
         nxt_q.cdis = monreg_pkg::RST_ZERO;
         nxt_q.deep = monreg_pkg::RST_ZERO;
         nxt_q.adv = monreg_pkg::RST_ZERO;
         nxt_q.res = '0;
         nxt_q.lim = '0;
      end
      nxt_q.busy = {6'h00, NOT_READY_I, CONV_BUSY_I};  // R9
      if (RESULT_WE_I) begin
         nxt_q.res[RESULT_CH_I] = RESULT_DATA_I;  // R10
      end
      // serial engine
      if (start_c) begin
         nxt_q.st = monreg_pkg::ST_ADDR;
         nxt_q.bitc = 3'h0;
         nxt_q.sda_drv = 1'b0;
         nxt_q.hi = 1'b1;
      end else if (stop_c) begin
         nxt_q.st = monreg_pkg::ST_IDLE;
         nxt_q.sda_drv = 1'b0;
      end else begin
         case (q_ff.st)
            monreg_pkg::ST_IDLE: begin
               nxt_q.sda_drv = 1'b0;
            end
            monreg_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  nxt_q.shf = byte_in;
                  nxt_q.bitc = q_ff.bitc + 3'h1;
                  if (q_ff.bitc == monreg_pkg::LAST_BIT) begin
                     nxt_q.rw = byte_in[0];
                     nxt_q.ptr_phase = ~byte_in[0];
                     nxt_q.st = (byte_in[7:1] == my_addr) ? monreg_pkg::ST_ACK
                                                           : monreg_pkg::ST_IDLE;  // R14
                  end
               end
            end
            monreg_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (!q_ff.sda_drv) begin
                     nxt_q.sda_drv = 1'b1;
                  end else begin
                     nxt_q.sda_drv = 1'b0;
                     nxt_q.bitc = 3'h0;
                     if (q_ff.rw) begin
                        do_load = 1'b1;
                     end else begin
                        nxt_q.st = monreg_pkg::ST_WR;
                     end
                  end
               end
            end
            monreg_pkg::ST_WR: begin
               if (scl_rise) begin
                  nxt_q.shf = byte_in;
                  nxt_q.bitc = q_ff.bitc + 3'h1;
                  if (q_ff.bitc == monreg_pkg::LAST_BIT) begin
                     nxt_q.st = monreg_pkg::ST_ACK;
                     nxt_q.ptr_phase = 1'b0;
                     if (q_ff.ptr_phase) begin
                        nxt_q.ptr = byte_in;
                        nxt_q.hi = 1'b1;
                     end else if (in_lim) begin
                        nxt_q.lim[lim_idx] = byte_in;  // R11
                     end else begin
                        case (q_ff.ptr)
                           monreg_pkg::OFS_CFG:     nxt_q.cfg = byte_in & monreg_pkg::CFG_WMASK;  // R1 R17
                           monreg_pkg::OFS_IMASK:   nxt_q.imask = byte_in;  // R3
                           monreg_pkg::OFS_CRATE:   nxt_q.crate = byte_in;  // R4
                           monreg_pkg::OFS_CDIS:    nxt_q.cdis = byte_in;  // R5
                           monreg_pkg::OFS_ONESHOT: trig_wr = 1'b1;  // R6 R16
                           monreg_pkg::OFS_DEEP:    nxt_q.deep = byte_in;  // R7
                           monreg_pkg::OFS_ADV:     nxt_q.adv = byte_in;  // R8
                           default:                 trig_wr = 1'b0;  // R18
                        endcase
                     end
                  end
               end
            end
            monreg_pkg::ST_RD: begin
               if (scl_fall) begin
                  if (q_ff.bitc == monreg_pkg::LAST_BIT) begin
                     nxt_q.sda_drv = 1'b0;
                     nxt_q.st = monreg_pkg::ST_RACK;
                  end else begin
                     nxt_q.shf = {q_ff.shf[6:0], 1'b0};
                     nxt_q.sda_drv = ~q_ff.shf[6];
                     nxt_q.bitc = q_ff.bitc + 3'h1;
                  end
               end
            end
            monreg_pkg::ST_RACK: begin
               if (scl_rise) begin
                  nxt_q.mack = ~sda_new;
               end else if (scl_fall) begin
                  if (q_ff.mack) begin
                     do_load = 1'b1;
                     nxt_q.bitc = 3'h0;
                  end else begin
                     nxt_q.st = monreg_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_q.st = monreg_pkg::ST_IDLE;
            end
         endcase
      end
      if (do_load) begin
         nxt_q.shf = rd_val;
         nxt_q.sda_drv = ~rd_val[7];
         nxt_q.st = monreg_pkg::ST_RD;
         if (in_res) begin
            nxt_q.hi = ~q_ff.hi;  // R10
         end
         if (q_ff.ptr == monreg_pkg::OFS_ISTS) begin
            nxt_q.ists = monreg_pkg::RST_ZERO;  // R15
            ists_rd = 1'b1;
         end
      end
      nxt_q.one_shot = trig_wr;  // R6
      nxt_q.ists = nxt_q.ists | STATUS_SET_I;  // R2
      nxt_q.int_drv = q_ff.cfg[monreg_pkg::BIT_INT_EN] & ~q_ff.cfg[monreg_pkg::BIT_INT_CLR]
                      & (|(q_ff.ists & ~q_ff.imask));  // R3
      nxt_q.lim_out = q_ff.lim[LIMIT_SEL_I];  // R11
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         q_ff <= RST_STATE;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign SDA_O             = 1'b0;
   assign SDA_OE_O          = q_ff.sda_drv;
   assign INT_O             = 1'b0;
   assign INT_OE_O          = q_ff.int_drv;
   assign START_O           = q_ff.cfg[monreg_pkg::BIT_START];
   assign MONITOR_HALT_O    = q_ff.cfg[monreg_pkg::BIT_INT_CLR];
   assign ONE_SHOT_O        = q_ff.one_shot;
   assign DEEP_SHUTDOWN_O   = q_ff.deep[monreg_pkg::BIT_DEEP];  // R7
   assign CONV_RATE_O       = q_ff.crate;
   assign CHANNEL_DISABLE_O = q_ff.cdis;
   assign ADV_CONFIG_O      = q_ff.adv;
   assign LIMIT_O           = q_ff.lim_out;
   assign BUS_ACTIVE_O      = (q_ff.st != monreg_pkg::ST_IDLE);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RESET_I);

   sequence trig_seen_s;
      trig_wr;
   endsequence
   sequence one_pulse_s;
      ONE_SHOT_O ##1 !ONE_SHOT_O;
   endsequence

   cfg_reset_a: assert property ($past(RESET_I) |-> q_ff.cfg == monreg_pkg::RST_CFG)  // R1
      else $error("config reset value wrong");
   busy_reset_a: assert property ($past(RESET_I) |-> q_ff.busy == monreg_pkg::RST_BUSY)  // R9
      else $error("busy reset value wrong");
   status_clear_a: assert property ((ists_rd && STATUS_SET_I == 8'h00) |=> q_ff.ists == 8'h00)  // R15
      else $error("status not cleared by read");
   set_wins_a: assert property (STATUS_SET_I != 8'h00  // R2
      |=> (q_ff.ists & $past(STATUS_SET_I)) == $past(STATUS_SET_I))
      else $error("status event lost");
   int_gate_a: assert property (INT_OE_O  // R3
      == $past(q_ff.cfg[monreg_pkg::BIT_INT_EN] && !q_ff.cfg[monreg_pkg::BIT_INT_CLR]
      && ((q_ff.ists & ~q_ff.imask) != 8'h00)))
      else $error("interrupt pin gating wrong");
   trig_pulse_a: assert property (trig_seen_s |=> one_pulse_s)  // R6
      else $error("trigger pulse missing");
   init_restore_a: assert property (q_ff.cfg[monreg_pkg::BIT_INIT]  // R17
      |=> q_ff.cfg == monreg_pkg::RST_CFG && q_ff.imask == 8'h00 && q_ff.lim == '0)
      else $error("init did not restore defaults");
   result_store_a: assert property (RESULT_WE_I  // R10
      |=> q_ff.res[$past(RESULT_CH_I)] == $past(RESULT_DATA_I))
      else $error("result not stored");
   trig_read_a: assert property ((do_load && q_ff.ptr == monreg_pkg::OFS_ONESHOT)  // R16
      |=> q_ff.shf == 8'h00)
      else $error("trigger offset read not zero");

endmodule

// ---- bus_host.sv ----
// two-wire bus host model: drives the link clock and pulls the data line low
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module bus_host (
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   localparam time QTR = 100;

   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   // ----------------------------------------
   // frame tasks, clock idles high outside frames
   // ----------------------------------------
   task automatic start_f();
      #QTR sda_low_o = 1'b0;
      #(2*QTR) scl_o = 1'b1;
      #(2*QTR) sda_low_o = 1'b1;
      #(2*QTR) scl_o = 1'b0;
   endtask

   task automatic stop_f();
      #QTR sda_low_o = 1'b1;
      #QTR scl_o = 1'b1;
      #(2*QTR) sda_low_o = 1'b0;
      #(4*QTR);
   endtask

   task automatic bit_f(input logic b, output logic seen);
      #QTR sda_low_o = ~b;
      #QTR scl_o = 1'b1;
      #QTR seen = sda_i;
      #QTR scl_o = 1'b0;
   endtask

   // rel high releases the ninth bit, low acknowledges a read byte
   task automatic byte_f(input logic [7:0] d, input logic rel,
                         output logic [7:0] got, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_f(d[i], got[i]);
      end
      bit_f(rel, a);
      ack = ~a;
   endtask
endmodule

// ---- testbench.sv ----
// self-checking bench of the monitor register bank over the two-wire bus
// assumes bus_host.sv and the design files are compiled before this file
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] MK = 8'h61;  // arbitrary value
   localparam logic [7:0] RV = 8'h17;  // arbitrary value
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [1:0]  lo = 2'h0, hi = 2'h0;
   logic [7:0]  st_set = 8'h00;
   logic        res_we = 1'b0;
   logic [2:0]  res_ch = 3'h0;
   logic [15:0] res_d = 16'h0000;
   logic        busy = 1'b0, nrdy = 1'b1;
   logic [3:0]  lim_sel = 4'h0;
   logic [6:0]  dev = 7'h1d;
   wire         scl, sda_low, sda_o, sda_oe, int_o, int_oe, start, halt, shot, deep, act;
   wire  [7:0]  crate, cdis, adv, lim;
   wire         sda_w = ~(sda_low | (sda_oe & ~sda_o));
   int          num_errors = 0, tests_run = 0, shots = 0;

   always #25 ref_clk = ~ref_clk;
   always @(negedge ref_clk) if (shot === 1'b1) shots++;

   bus_host i_bus_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
   monitor_register_bank #(.MAKER_CODE(MK), .REV_CODE(RV)) i_monitor_register_bank (
      .REF_CLK_I(ref_clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .ADDR_SELECT_LOW_PIN_I(lo), .ADDR_SELECT_HIGH_PIN_I(hi),
      .STATUS_SET_I(st_set), .RESULT_WE_I(res_we), .RESULT_CH_I(res_ch),
      .RESULT_DATA_I(res_d), .CONV_BUSY_I(busy), .NOT_READY_I(nrdy), .LIMIT_SEL_I(lim_sel),
      .LIMIT_O(lim), .INT_O(int_o), .INT_OE_O(int_oe), .START_O(start),
      .MONITOR_HALT_O(halt), .ONE_SHOT_O(shot), .DEEP_SHUTDOWN_O(deep),
      .CONV_RATE_O(crate), .CHANNEL_DISABLE_O(cdis), .ADV_CONFIG_O(adv),
      .BUS_ACTIVE_O(act));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic do_reset();
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(8);
   endtask

   task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] g;
      logic       a;
      i_bus_host.start_f();
      i_bus_host.byte_f({dev, 1'b0}, 1'b1, g, a);
      i_bus_host.byte_f(ptr, 1'b1, g, a);
      i_bus_host.byte_f(d, 1'b1, g, a);
      i_bus_host.stop_f();
   endtask

   task automatic reg_rd(input logic [7:0] ptr, input int n, output logic [15:0] v);
      logic [7:0] g;
      logic       a;
      v = 16'h0000;
      i_bus_host.start_f();
      i_bus_host.byte_f({dev, 1'b0}, 1'b1, g, a);
      i_bus_host.byte_f(ptr, 1'b1, g, a);
      i_bus_host.start_f();
      i_bus_host.byte_f({dev, 1'b1}, 1'b1, g, a);
      for (int i = 0; i < n; i++) begin
         i_bus_host.byte_f(8'hff, i == n - 1, g, a);
         v = {v[7:0], g};
      end
      i_bus_host.stop_f();
   endtask

   task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
      logic [15:0] v;
      reg_rd(ptr, 1, v);
      check($sformatf("offset %h", ptr), {8'h00, exp}, v);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
                               8'h0c, 8'h3e, 8'h3f};
      logic [7:0] exp [11] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h02, MK, RV};
      for (int i = 0; i < 11; i++) rd_chk(ofs[i], exp[i]);
      busy = 1'b1;
      nrdy = 1'b0;
      rd_chk(8'h0c, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_rw();
      logic [7:0] ofs [5] = '{8'h03, 8'h07, 8'h08, 8'h0a, 8'h0b};
      for (int i = 0; i < 5; i++) reg_wr(ofs[i], 8'ha5);
      for (int i = 0; i < 5; i++) rd_chk(ofs[i], 8'ha5);
      check("rate port", 16'h00a5, {8'h00, crate});
      check("disable port", 16'h00a5, {8'h00, cdis});
      check("deep port", 16'h0001, {15'h0000, deep});
      check("adv port", 16'h00a5, {8'h00, adv});
      reg_wr(8'h00, 8'h7f);
      rd_chk(8'h00, 8'h0b);
      check("start port", 16'h0001, {15'h0000, start});
      check("halt port", 16'h0001, {15'h0000, halt});
      reg_wr(8'h00, 8'h00);
      $display("test rw done");
   endtask

   task automatic t_trig();
      shots = 0;
      reg_wr(8'h09, 8'hff);
      check("trigger pulses", 16'h0001, shots[15:0]);
      rd_chk(8'h09, 8'h00);
      $display("test trigger done");
   endtask

   task automatic t_res();
      logic [15:0] v;
      res_we = 1'b1;
      res_ch = 3'h3;
      res_d  = 16'hbeef;
      tick(1);
      res_ch = 3'h7;
      res_d  = 16'h0123;
      tick(1);
      res_we = 1'b0;
      reg_rd(8'h23, 2, v);
      check("result 3", 16'hbeef, v);
      reg_rd(8'h27, 3, v);
      check("result 7 wrap", 16'h2301, v);
      $display("test results done");
   endtask

   task automatic t_lim();
      reg_wr(8'h2a, 8'h11);
      reg_wr(8'h39, 8'h99);
      rd_chk(8'h2a, 8'h11);
      rd_chk(8'h39, 8'h99);
      lim_sel = 4'hf;
      tick(2);
      check("limit port", 16'h0099, {8'h00, lim});
      $display("test limits done");
   endtask

   task automatic t_irq();
      reg_wr(8'h03, 8'h00);
      reg_wr(8'h00, 8'h02);
      st_set = 8'h81;
      tick(1);
      st_set = 8'h00;
      tick(2);
      check("irq raised", 16'h0001, {15'h0000, int_oe});
      check("int level", 16'h0000, {15'h0000, int_o});
      rd_chk(8'h01, 8'h81);
      check("irq cleared", 16'h0000, {15'h0000, int_oe});
      rd_chk(8'h01, 8'h00);
      reg_wr(8'h03, 8'h80);
      st_set = 8'h80;
      tick(1);
      st_set = 8'h00;
      tick(2);
      check("irq masked", 16'h0000, {15'h0000, int_oe});
      rd_chk(8'h01, 8'h80);
      $display("test irq done");
   endtask

   task automatic t_unmap();
      reg_wr(8'h02, 8'hff);
      reg_wr(8'h0c, 8'hff);
      reg_wr(8'h01, 8'hff);
      rd_chk(8'h02, 8'h00);
      rd_chk(8'h28, 8'h00);
      rd_chk(8'h0c, 8'h01);
      rd_chk(8'h01, 8'h00);
      $display("test unmapped done");
   endtask

   task automatic t_init();
      reg_wr(8'h07, 8'h5a);
      reg_wr(8'h00, 8'h83);
      rd_chk(8'h00, 8'h08);
      rd_chk(8'h07, 8'h00);
      $display("test init done");
   endtask

   task automatic t_addr();
      logic [7:0] g;
      logic       a;
      int         idx;
      for (int k = 0; k < 10; k++) begin
         hi = (k > 8) ? 2'h3 : 2'(k / 3);
         lo = (k > 8) ? 2'h3 : 2'(k % 3);
         idx = (k > 8) ? 8 : k;
         do_reset();
         for (int j = 0; j < 2; j++) begin
            dev = monreg_pkg::ADDR_BASE + 7'((idx + j) % 9);
            i_bus_host.start_f();
            i_bus_host.byte_f({dev, 1'b0}, 1'b1, g, a);
            check("engine active", {15'h0000, j == 0}, {15'h0000, act});
            i_bus_host.stop_f();
            check($sformatf("ack %h", dev), {15'h0000, j == 0}, {15'h0000, a});
         end
      end
      $display("test address done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #4ms;
      num_errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      conclude();
   end

   initial begin
      do_reset();
      t_reset();
      t_rw();
      t_trig();
      t_res();
      t_lim();
      t_irq();
      t_unmap();
      t_init();
      t_addr();
      conclude();
   end
endmodule
